/* hdl/scb_core.sv */
// Command decoder, mode register and burst column sequencer of an SDRAM.
`timescale 1ns/1ns
`include "scb_defines.svh"
// What this block does
// - Normal mode only with both op bits zero
// - Write-burst bit makes writes single column
// - Sequential adds offset, interleaved XORs it
// - Upper column bits fix aligned block
// - Burst wraps inside its block
// - Full page wraps whole row, sequential only
// - Length one uses full column, ignores order
// - Read latency two or three clocks
// - Drive from n+m-1, valid at n+m
// - Activate decode opens row in bank
// - Read and write decode start bursts
// - Precharge and burst terminate decode
// - Refresh and load mode decode
// - Refresh with clock gate low means self refresh
// - Refresh uses internal row counter
// - Mode op-code from address 0 to 11
// - Activate takes row and bank
// - Column width depends on organisation
// - Auto precharge per command only
// - Precharge one bank or all
// - Mask: writes now, reads two clocks later
// - Deselect takes no command, work continues
// - Mode fields: length, order, latency
module scb_core (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Configuration.
  input  wire logic [1:0]  org_sel,
  // Command pins.
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic        cke,
  input  wire logic        bank_select_lo,
  input  wire logic        bank_select_hi,
  input  wire logic [12:0] addr,
  input  wire logic        dqm,
  // Array side.
  output logic             col_valid_ff,
  output logic             col_is_write_ff,
  output logic [10:0]      col_addr_ff,
  output logic [1:0]       col_bank_ff,
  output logic             wr_mask_ff,
  output logic             dq_oe_ff,
  output logic             rd_valid_ff,
  output logic [3:0]       bank_open_ff,
  output logic [12:0]      act_row_ff,
  output logic [12:0]      ref_row_ff,
  output logic             auto_pre_ff,
  output logic             self_refresh_ff,
  output logic [11:0]      mode_reg_ff,
  output logic             mode_bad_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // Command decode.

  // One decoder for the live command pins.
  function automatic scb_pkg::scb_cmd_e dec_cmd(input logic cs, input logic r, input logic c, input logic w);
    if (cs) begin
      dec_cmd = scb_pkg::CMD_INH;
    end else begin
      case ({r, c, w})
        3'h7:    dec_cmd = scb_pkg::CMD_NOP;
        3'h3:    dec_cmd = scb_pkg::CMD_ACT;
        3'h5:    dec_cmd = scb_pkg::CMD_RD;
        3'h4:    dec_cmd = scb_pkg::CMD_WR;
        3'h6:    dec_cmd = scb_pkg::CMD_BST;
        3'h2:    dec_cmd = scb_pkg::CMD_PRE;
        3'h1:    dec_cmd = scb_pkg::CMD_REF;
        default: dec_cmd = scb_pkg::CMD_LMR;
      endcase
    end
  endfunction : dec_cmd

  scb_pkg::scb_state_e state_ff;
  scb_pkg::scb_state_e nxt_state;
  scb_pkg::scb_cmd_e   cmd;
  wire logic           in_self;
  wire logic [1:0]     bank_in;

  // Deselect decodes to inhibit, so nothing new starts but bursts run on.
  // deselect inhibits commands
  assign cmd     = dec_cmd(cs_n, ras_n, cas_n, we_n);
  assign in_self = (state_ff == scb_pkg::SCB_SELF);
  assign bank_in = {bank_select_hi, bank_select_lo};

  wire logic is_act = !in_self && cke && (cmd == scb_pkg::CMD_ACT);
  wire logic is_rd  = !in_self && cke && (cmd == scb_pkg::CMD_RD);
  wire logic is_wr  = !in_self && cke && (cmd == scb_pkg::CMD_WR);
  wire logic is_bst = !in_self && cke && (cmd == scb_pkg::CMD_BST);
  wire logic is_pre = !in_self && cke && (cmd == scb_pkg::CMD_PRE);
  wire logic is_lmr = !in_self && cke && (cmd == scb_pkg::CMD_LMR);
  wire logic is_aref = !in_self && cke && (cmd == scb_pkg::CMD_REF);
  wire logic is_sref = !in_self && !cke && (cmd == scb_pkg::CMD_REF);

  ////////////////////////////////////////////////////////////////////////////
  // Mode register fields.

  wire logic [2:0] bl_code  = mode_reg_ff[`SCB_MR_BL_MSB:`SCB_MR_BL_LSB];
  wire logic [2:0] rl_code  = mode_reg_ff[`SCB_MR_RL_MSB:`SCB_MR_RL_LSB];
  wire logic       burst_order_bit    = mode_reg_ff[`SCB_MR_ORDER_BIT];
  wire logic       op_mode_bit_lo     = mode_reg_ff[`SCB_MR_OPLO_BIT];
  wire logic       op_mode_bit_hi     = mode_reg_ff[`SCB_MR_OPHI_BIT];
  wire logic       write_burst_select = mode_reg_ff[`SCB_MR_WBS_BIT];

  wire logic bl_ok = (bl_code <= `SCB_BL_8) || (bl_code == `SCB_BL_PAGE);
  wire logic rl_ok = (rl_code == `SCB_RL_2) || (rl_code == `SCB_RL_3);
  wire logic op_ok = !op_mode_bit_lo && !op_mode_bit_hi;
  // Reserved burst codes fall back to length one so ordering stays defined.
  wire logic [2:0] bl_eff = bl_ok ? bl_code : `SCB_BL_1;
  wire logic       rl3 = (rl_code == `SCB_RL_3);

  ////////////////////////////////////////////////////////////////////////////
  // Column capture and offset mask.

  wire logic [10:0] page_mask = (org_sel == `SCB_ORG_X4) ? `SCB_PAGE_X4 :
                                (org_sel == `SCB_ORG_X8) ? `SCB_PAGE_X8 : `SCB_PAGE_X16;
  wire logic [10:0] col_in = {addr[`SCB_COL_HI_BIT], addr[9:0]} & page_mask;

  wire logic [2:0] bl_cmd = (is_wr && write_burst_select) ? `SCB_BL_1 : bl_eff;
  wire logic       page_cmd = (bl_cmd == `SCB_BL_PAGE);
  wire logic [10:0] off_mask = page_cmd ? page_mask : {8'h00, (3'h1 << bl_cmd) - 3'h1};
  wire logic [10:0] beats    = page_cmd ? page_mask : {8'h00, (3'h1 << bl_cmd) - 3'h1};

  ////////////////////////////////////////////////////////////////////////////
  // Burst sequencer state.

  logic [10:0] base_ff;
  logic [10:0] start_ff;
  logic [10:0] mask_ff;
  logic [10:0] idx_ff;
  logic [10:0] left_ff;
  logic        inter_ff;
  logic        page_ff;
  logic        rd_pipe_ff;
  logic        dqm_pipe_ff;

  wire logic burst_on = (state_ff == scb_pkg::SCB_READ) || (state_ff == scb_pkg::SCB_WRITE);
  wire logic burst_end = burst_on && (left_ff == 11'h000);
  wire logic [10:0] idx_nxt = (idx_ff + 11'h001) & mask_ff;

  wire logic [10:0] off_seq = (start_ff + idx_ff) & mask_ff;
  wire logic [10:0] off_int = (start_ff ^ idx_ff) & mask_ff;
  wire logic [10:0] cur_col = base_ff | ((inter_ff && !page_ff) ? off_int : off_seq);

  // New read or write restarts the burst; terminate or end closes it.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      scb_pkg::SCB_SELF:  nxt_state = cke ? scb_pkg::SCB_IDLE : scb_pkg::SCB_SELF;
      default: begin
        if (is_sref)
          nxt_state = scb_pkg::SCB_SELF;
        else if (is_rd)
          nxt_state = scb_pkg::SCB_READ;
        else if (is_wr)
          nxt_state = scb_pkg::SCB_WRITE;
        else if (is_bst || burst_end)
          nxt_state = scb_pkg::SCB_IDLE;
      end
    endcase
  end

  // Burst registers.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= scb_pkg::SCB_IDLE;
      base_ff  <= 11'h000;
      start_ff <= 11'h000;
      mask_ff  <= 11'h000;
      idx_ff   <= 11'h000;
      left_ff  <= 11'h000;
      inter_ff <= 1'b0;
      page_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (is_rd || is_wr) begin
        base_ff  <= col_in & ~off_mask;
        start_ff <= col_in & off_mask;
        mask_ff  <= off_mask;
        idx_ff   <= 11'h000;
        left_ff  <= beats;
        inter_ff <= burst_order_bit && (bl_cmd != `SCB_BL_1);
        page_ff  <= page_cmd;
      end else if (burst_on) begin
        idx_ff  <= idx_nxt;
        left_ff <= left_ff - 11'h001;
      end
    end
  end

  // Column strobe out, one per cycle while a burst runs in normal operating mode.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      col_valid_ff    <= 1'b0;
      col_is_write_ff <= 1'b0;
      col_addr_ff     <= 11'h000;
    end else begin
      col_valid_ff    <= burst_on && !is_bst && op_ok;
      col_is_write_ff <= (state_ff == scb_pkg::SCB_WRITE);
      col_addr_ff     <= cur_col;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read latency and byte mask pipeline.

  // The read state already lags one edge, so latency two drives at n+1.
  // output enable from n+m-1
  wire logic rd_beat = (state_ff == scb_pkg::SCB_READ) && !is_bst;
  wire logic rd_tap  = rl3 ? rd_pipe_ff : rd_beat;
  // The enable leads its data by one edge, so one mask stage gives the two-clock mask latency.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_pipe_ff  <= 1'b0;
      dqm_pipe_ff <= 1'b1;
      dq_oe_ff    <= 1'b0;
      rd_valid_ff <= 1'b0;
      wr_mask_ff  <= 1'b1;
    end else begin
      rd_pipe_ff  <= rd_beat;
      dqm_pipe_ff <= dqm;
      dq_oe_ff    <= rd_tap && !dqm_pipe_ff;
      rd_valid_ff <= dq_oe_ff;
      // Write mask applies to the beat of the same clock.
      wr_mask_ff  <= dqm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Banks, rows, refresh and mode register.

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bank_open_ff    <= 4'h0;
      act_row_ff      <= `SCB_ROW_RESET;
      ref_row_ff      <= `SCB_ROW_RESET;
      col_bank_ff     <= 2'h0;
      auto_pre_ff     <= 1'b0;
      self_refresh_ff <= 1'b0;
      mode_reg_ff     <= `SCB_MR_RESET;
      mode_bad_ff     <= 1'b0;
    end else begin
      self_refresh_ff <= (nxt_state == scb_pkg::SCB_SELF);
      mode_bad_ff     <= !(bl_ok && rl_ok && op_ok);
      if (is_act) begin
        bank_open_ff[bank_in] <= 1'b1;
        act_row_ff            <= addr;
      end
      if (is_pre) begin
        if (addr[`SCB_PRE_SEL_BIT])
          bank_open_ff <= 4'h0;
        else
          bank_open_ff[bank_in] <= 1'b0;
      end
      if (is_rd || is_wr) begin
        col_bank_ff <= bank_in;
        auto_pre_ff <= addr[`SCB_PRE_SEL_BIT] && !page_cmd;
      end
      if (is_aref || is_sref)
        ref_row_ff <= ref_row_ff + 13'h0001;
      if (is_lmr)
        mode_reg_ff <= addr[11:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_inhibit_holds: assert property (@(posedge clock) disable iff (!arst_n)
    cs_n |=> (mode_reg_ff == $past(mode_reg_ff)) && (bank_open_ff == $past(bank_open_ff)))
    else $error("deselect changed state");
  a_lmr_loads: assert property (@(posedge clock) disable iff (!arst_n)
    is_lmr |=> mode_reg_ff == $past(addr[11:0]))
    else $error("mode load wrong");
  a_pre_all: assert property (@(posedge clock) disable iff (!arst_n)
    (is_pre && addr[`SCB_PRE_SEL_BIT] && !is_act) |=> bank_open_ff == 4'h0)
    else $error("precharge all failed");
  a_act_opens: assert property (@(posedge clock) disable iff (!arst_n)
    (is_act && !is_pre) |=> bank_open_ff[$past(bank_in)])
    else $error("activate did not open");
  a_single_write: assert property (@(posedge clock) disable iff (!arst_n)
    (is_wr && write_burst_select) |=> left_ff == 11'h000)
    else $error("write not single");
  a_col_in_block: assert property (@(posedge clock) disable iff (!arst_n)
    (col_valid_ff && $past(col_valid_ff) && !$past(is_rd, 2) && !$past(is_wr, 2))
      |-> ((col_addr_ff & ~$past(mask_ff)) == ($past(col_addr_ff) & ~$past(mask_ff))))
    else $error("burst left block");
  a_sref_enter: assert property (@(posedge clock) disable iff (!arst_n)
    is_sref |=> self_refresh_ff)
    else $error("self refresh missed");
  a_ref_count: assert property (@(posedge clock) disable iff (!arst_n)
    is_aref |=> ref_row_ff == $past(ref_row_ff) + 13'h0001)
    else $error("refresh row stuck");
  a_rd_lat2: assert property (@(posedge clock) disable iff (!arst_n)
    (rd_beat && !rl3 && !dqm_pipe_ff) |=> dq_oe_ff)
    else $error("latency two enable late");

endmodule : scb_core

/* hdl/scb_defines.svh */
// Constants for the SDRAM command, mode and burst sequencer.
`ifndef SCB_DEFINES_SVH
`define SCB_DEFINES_SVH
`define SCB_MR_BL_LSB      0
`define SCB_MR_BL_MSB      2
`define SCB_MR_ORDER_BIT   3
`define SCB_MR_RL_LSB      4
`define SCB_MR_RL_MSB      6
`define SCB_MR_OPLO_BIT    7
`define SCB_MR_OPHI_BIT    8
`define SCB_MR_WBS_BIT     9
`define SCB_MR_RESET       12'h022
`define SCB_BL_1           3'h0
`define SCB_BL_2           3'h1
`define SCB_BL_4           3'h2
`define SCB_BL_8           3'h3
`define SCB_BL_PAGE        3'h7
`define SCB_RL_2           3'h2
`define SCB_RL_3           3'h3
`define SCB_MASK_LAT       2
`define SCB_PRE_SEL_BIT    10
`define SCB_COL_HI_BIT     11
`define SCB_ORG_X4         2'h0
`define SCB_ORG_X8         2'h1
`define SCB_ORG_X16        2'h2
`define SCB_PAGE_X4        11'h7ff
`define SCB_PAGE_X8        11'h3ff
`define SCB_PAGE_X16       11'h1ff
`define SCB_ROW_RESET      13'h0000
`endif

/* hdl/scb_pkg.sv */
// Types for the SDRAM command, mode and burst sequencer.
package scb_pkg;
  typedef enum logic [3:0] {
    SCB_IDLE  = 4'b0001,
    SCB_READ  = 4'b0010,
    SCB_WRITE = 4'b0100,
    SCB_SELF  = 4'b1000
  } scb_state_e;
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0, CMD_ACT = 4'h1, CMD_RD = 4'h2, CMD_WR = 4'h3,
    CMD_BST = 4'h4, CMD_PRE = 4'h5, CMD_REF = 4'h6, CMD_LMR = 4'h7,
    CMD_INH = 4'h8
  } scb_cmd_e;
endpackage : scb_pkg

/* test/scb_core_tb.sv */
// Self-checking bench for the SDRAM command, mode and burst sequencer.
`timescale 1ns/1ns
`include "scb_defines.svh"
module scb_core_tb;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic [1:0]  org_sel = `SCB_ORG_X8;
  logic        cs_n, ras_n, cas_n, we_n, cke, bank_select_lo, bank_select_hi, dqm;
  logic        col_valid_ff, col_is_write_ff, wr_mask_ff, dq_oe_ff, rd_valid_ff;
  logic        auto_pre_ff, self_refresh_ff, mode_bad_ff;
  logic [10:0] col_addr_ff;
  logic [1:0]  col_bank_ff;
  logic [3:0]  bank_open_ff;
  logic [12:0] addr, act_row_ff, ref_row_ff, r;
  logic [11:0] mode_reg_ff;
  int          n_fail = 0;
  int          n_compared = 0;
  // Pin patterns {cs_n, ras_n, cas_n, we_n}; DES carries a read under a high select.
  localparam logic [3:0] LMR = 4'h0, REF = 4'h1, PRE = 4'h2, ACT = 4'h3, WR = 4'h4, RD = 4'h5;
  localparam logic [3:0] BST = 4'h6, NOP = 4'h7, DES = 4'hd;
  // A 4 ns half period gives 125 MHz.
  always #4 clock = ~clock;
  scb_ctrl_model scb_ctrl_model_i (.clock, .cs_n, .ras_n, .cas_n, .we_n, .cke, .bank_select_lo,
    .bank_select_hi, .addr, .dqm);
  scb_core scb_core_i (.clock, .arst_n, .org_sel, .cs_n, .ras_n, .cas_n, .we_n, .cke, .bank_select_lo,
    .bank_select_hi, .addr, .dqm, .col_valid_ff, .col_is_write_ff, .col_addr_ff, .col_bank_ff,
    .wr_mask_ff, .dq_oe_ff, .rd_valid_ff, .bank_open_ff, .act_row_ff, .ref_row_ff, .auto_pre_ff,
    .self_refresh_ff, .mode_reg_ff, .mode_bad_ff);
  ////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts a mismatch.
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Prints the verdict and ends the run.
  task automatic give_verdict;
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // Closes every bank, loads the mode register, reads it back and reopens bank two.
  // The reopen also gives the mode flag its one extra edge to settle.
  task automatic lmr(input logic [11:0] m);
    scb_ctrl_model_i.issue(PRE, 2'h0, 13'h0400, 1'b1, 1'b0);
    scb_ctrl_model_i.issue(LMR, 2'h0, {1'b0, m}, 1'b1, 1'b0);
    check(mode_reg_ff, m);
    scb_ctrl_model_i.issue(ACT, 2'h2, 13'h1abc, 1'b1, 1'b0);
  endtask : lmr
  // Checks n beats from start s within the block given by mask m.
  task automatic beats(input logic [10:0] s, input logic [10:0] m, input int n, input logic il, input logic wr,
                       input logic fin);
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      check(col_valid_ff, 1'b1);
      check(col_is_write_ff, wr);
      check(col_addr_ff, (s & ~m) | ((il ? s ^ 11'(i) : s + 11'(i)) & m));
    end
    if (fin) begin
      @(negedge clock);
      check(col_valid_ff, 1'b0);
    end
  endtask : beats
  ////////////////////////////////////////////////////////////////////////////
  // Lengths two to eight in both orders, write burst select, length one and full page.
  task automatic s_bursts;
    scb_ctrl_model_i.issue(ACT, 2'h2, 13'h1abc, 1'b1, 1'b0);
    check(bank_open_ff, 4'h4);
    check(act_row_ff, 13'h1abc);
    for (int b = 1; b < 4; b++) begin
      for (int il = 0; il < 2; il++) begin
        lmr({5'h00, `SCB_RL_2, 1'(il), 3'(b)});
        scb_ctrl_model_i.issue(RD, 2'h2, 13'h12b5, 1'b1, 1'b0);
        beats(11'h2b5, 11'((1 << b) - 1), 1 << b, 1'(il), 1'b0, 1'b1);
        check(col_bank_ff, 2'h2);
      end
    end
    for (int w = 0; w < 2; w++) begin
      lmr({2'h0, 1'(w), 2'h0, `SCB_RL_2, 1'b0, `SCB_BL_8});
      scb_ctrl_model_i.issue(WR, 2'h2, 13'h0013, 1'b1, 1'b0);
      beats(11'h013, 11'h007, w ? 1 : 8, 1'b0, 1'b1, 1'b1);
    end
    org_sel = `SCB_ORG_X4;
    lmr({5'h00, `SCB_RL_2, 1'b1, `SCB_BL_1});
    scb_ctrl_model_i.issue(RD, 2'h2, 13'h0dff, 1'b1, 1'b0);
    beats(11'h5ff, 11'h000, 1, 1'b1, 1'b0, 1'b1);
    check(auto_pre_ff, 1'b1);
    org_sel = `SCB_ORG_X16;
    lmr({5'h00, `SCB_RL_2, 1'b0, `SCB_BL_PAGE});
    scb_ctrl_model_i.issue(RD, 2'h2, 13'h03fe, 1'b1, 1'b0);
    beats(11'h1fe, `SCB_PAGE_X16, 3, 1'b0, 1'b0, 1'b0);
    scb_ctrl_model_i.issue(BST, 2'h2, 13'h0000, 1'b1, 1'b0);
    @(negedge clock);
    check(col_valid_ff, 1'b0);
    org_sel = `SCB_ORG_X8;
  endtask : s_bursts
  // Read latency two and three with the read mask low and high.
  task automatic s_latency;
    for (int k = 0; k < 4; k++) begin
      lmr({5'h00, k[1] ? `SCB_RL_3 : `SCB_RL_2, 1'b0, `SCB_BL_1});
      scb_ctrl_model_i.issue(RD, 2'h2, 13'h0001, 1'b1, k[0]);
      check(wr_mask_ff, k[0]);
      for (int j = 1; j <= 3 + k[1]; j++) begin
        @(negedge clock);
        check(dq_oe_ff, j == 1 + k[1] && !k[0]);
        check(rd_valid_ff, j == 2 + k[1] && !k[0]);
      end
    end
    check(auto_pre_ff, 1'b0);
  endtask : s_latency
  // Opens all banks, closes one, then all.
  task automatic s_banks;
    scb_ctrl_model_i.issue(PRE, 2'h0, 13'h0400, 1'b1, 1'b0);
    for (int b = 0; b < 4; b++) scb_ctrl_model_i.issue(ACT, 2'(b), 13'h0040, 1'b1, 1'b0);
    check(bank_open_ff, 4'hf);
    scb_ctrl_model_i.issue(PRE, 2'h1, 13'h0000, 1'b1, 1'b0);
    check(bank_open_ff, 4'hd);
    scb_ctrl_model_i.issue(PRE, 2'h1, 13'h0400, 1'b1, 1'b0);
    check(bank_open_ff, 4'h0);
  endtask : s_banks
  // Auto refresh, self refresh entry, an ignored read, then exit.
  task automatic s_refresh;
    r = ref_row_ff;
    scb_ctrl_model_i.issue(REF, 2'h3, 13'h1fff, 1'b1, 1'b0);
    check(ref_row_ff != r, 1'b1);
    check(self_refresh_ff, 1'b0);
    scb_ctrl_model_i.issue(REF, 2'h0, 13'h0000, 1'b0, 1'b0);
    check(self_refresh_ff, 1'b1);
    scb_ctrl_model_i.issue(RD, 2'h2, 13'h0001, 1'b0, 1'b0);
    @(negedge clock);
    check(col_valid_ff, 1'b0);
    scb_ctrl_model_i.issue(NOP, 2'h0, 13'h0000, 1'b1, 1'b0);
    repeat (2) @(negedge clock);
    check(self_refresh_ff, 1'b0);
  endtask : s_refresh
  // Deselect, a test operating mode and a reserved length.
  task automatic s_misc;
    scb_ctrl_model_i.issue(DES, 2'h2, 13'h0000, 1'b1, 1'b0);
    @(negedge clock);
    check(col_valid_ff, 1'b0);
    lmr({3'h0, 2'h1, `SCB_RL_2, 1'b0, `SCB_BL_2});
    check(mode_bad_ff, 1'b1);
    scb_ctrl_model_i.issue(RD, 2'h2, 13'h0000, 1'b1, 1'b0);
    @(negedge clock);
    check(col_valid_ff, 1'b0);
    lmr({5'h00, `SCB_RL_2, 1'b0, 3'h4});
    check(mode_bad_ff, 1'b1);
    scb_ctrl_model_i.issue(RD, 2'h2, 13'h0006, 1'b1, 1'b0);
    beats(11'h006, 11'h000, 1, 1'b0, 1'b0, 1'b1);
  endtask : s_misc
  ////////////////////////////////////////////////////////////////////////////
  // Reset for eight cycles, check reset values, then run every scenario.
  initial begin
    repeat (8) @(negedge clock);
    check(mode_reg_ff, `SCB_MR_RESET);
    check(wr_mask_ff, 1'b1);
    arst_n = 1'b1;
    s_bursts();
    s_latency();
    s_misc();
    s_banks();
    s_refresh();
    give_verdict();
  end
endmodule : scb_core_tb

/* test/scb_ctrl_model.sv */
// Memory controller model that drives the command pins of the sequencer.
`timescale 1ns/1ns
module scb_ctrl_model (
  // Clock.
  input  wire logic        clock,
  // Command pins.
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic             cke,
  output logic             bank_select_lo,
  output logic             bank_select_hi,
  output logic [12:0]      addr,
  output logic             dqm
);
  // Pins start deselected with the clock gate high.
  initial begin
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    {cke, bank_select_hi, bank_select_lo, dqm} = 4'h8;
    addr = 13'h0000;
  end
  // One command every other cycle off the falling edge, deselected between; the caller keeps loads to idle banks.
  task automatic issue(input logic [3:0] p, input logic [1:0] b, input logic [12:0] a, input logic g, input logic m);
    @(negedge clock);
    {cs_n, ras_n, cas_n, we_n} = p;
    {bank_select_hi, bank_select_lo} = b;
    addr = (p == 4'h0) ? {1'b0, a[11:0]} : a;
    cke = g;
    dqm = m;
    @(negedge clock);
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    // A released bus shows the inverse so stale values never match.
    addr = ~a;
  endtask : issue
endmodule : scb_ctrl_model
